// ---- common/i2ctr_pkg.sv ----
// Shared constants and carrier types for the I2C register target
package i2ctr_pkg;

  // Target address used until the fuse store supplies one
  localparam logic [6:0] TARGET_ADDR_DFLT = 7'h1f;

  // System clock period and input spike width
  localparam int CLK_PERIOD_NS = 40;
  localparam int SPIKE_NS      = 50;
  // Spike width in whole cycles, rounded down, never under one cycle
  localparam int SPIKE_CYC_I   = SPIKE_NS / CLK_PERIOD_NS;
  localparam logic [2:0] SPIKE_CYC =
    (SPIKE_CYC_I < 1) ? 3'h1 : SPIKE_CYC_I[2:0];

  // Reset level of the filtered bus lines (pulled up)
  localparam logic LINE_IDLE = 1'b1;
  // Last bit index of a byte
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Byte events passed from the link to the pointer logic
  typedef enum logic [1:0] {
    EV_ADDR_W,
    EV_ADDR_R,
    EV_DATA_W,
    EV_TX_DONE
  } i2ctr_ev_kind_t;

  typedef struct packed {
    i2ctr_ev_kind_t kind;
    logic [7:0]     data;
  } i2ctr_ev_t;

  // Link state machine on SCL
  typedef enum logic [2:0] {
    LK_IDLE,
    LK_ADDR,
    LK_ADDR_ACK,
    LK_RX,
    LK_RX_ACK,
    LK_TX,
    LK_TX_ACK,
    LK_IGNORE
  } i2ctr_lk_state_t;

  typedef struct packed {
    i2ctr_lk_state_t st;
    logic [2:0]      cnt;
    logic            oe;
    logic [7:0]      tx;
    logic            rw;
    i2ctr_ev_t       ev;
    logic            ev_tog;
  } i2ctr_lk_t;

  // Request towards the register file
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } i2ctr_reg_req_t;

endpackage

// ---- core/i2ctr_pinfilt.sv ----
// Three-stage synchroniser with spike suppression for one bus pin
`timescale 1ns/1ps
module i2ctr_pinfilt
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Raw pin and filtered level
  input  wire logic pin,
  output logic      level
);

  logic       s1_q, s2_q, s3_q;
  logic       lvl_q, lvl_d;
  logic [2:0] cnt_q, cnt_d;

  // A new level must agree on stages two and three for two cycles in a row
  always_comb
  begin
    cnt_d = cnt_q;
    lvl_d = lvl_q;
    if (s2_q != s3_q || s3_q == lvl_q)
      cnt_d = 3'h0;
    else if (cnt_q == i2ctr_pkg::SPIKE_CYC)
    begin
      lvl_d = s3_q;
      cnt_d = 3'h0;
    end
    else
      cnt_d = cnt_q + 3'h1;
  end

  // Stage one feeds stage two only
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_q  <= i2ctr_pkg::LINE_IDLE;
      s2_q  <= i2ctr_pkg::LINE_IDLE;
      s3_q  <= i2ctr_pkg::LINE_IDLE;
      lvl_q <= i2ctr_pkg::LINE_IDLE;
      cnt_q <= 3'h0;
    end
    else
    begin
      s1_q  <= pin;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
      cnt_q <= cnt_d;
    end
  end

  assign level = lvl_q;

  // (RL18) spike rejection check
  AST_SPIKE_HOLD: assert property (@(posedge clk) disable iff (rst) // RL18
    $changed(lvl_q) |-> ($past(s3_q) == lvl_q && $past(s3_q, 2) == lvl_q))
    else $error("filtered level moved on a short pulse");

endmodule

// ---- core/i2ctr_top.sv ----
// I2C register-access target: bit logic on SCL, pointer logic on clk
`timescale 1ns/1ps
// Overview of operation
// (RL1) Answer a 7-bit target address, 1F by default, fuse may override.
// (RL2) Every byte moves most significant bit first.
// (RL3) SDA changes only with SCL low; changes while high are START/STOP.
// (RL4) Watch for START always; ignore the bus until one is seen.
// (RL5) Controller ends each transaction with STOP.
// (RL6) Transmitter releases SDA after eight bits; receiver pulls low on ninth.
// (RL7) Acknowledge a matching address byte following START.
// (RL8) In a write, acknowledge the register address and every data byte.
// (RL9) Controller acknowledges read bytes while it wants more.
// (RL10) Write is START, address+0, register address, data bytes, STOP.
// (RL11) Increment the register pointer after storing each data byte.
// (RL12) Discard a data byte cut short by STOP.
// (RL13) Read is dummy write, repeated START, address+1; all acknowledged.
// (RL14) Read sends from the pointer, incrementing after every byte.
// (RL15) Controller ends a read with STOP after the last byte.
// (RL16) Work in Standard, Fast, Fast-plus and High Speed modes.
// (RL17) SCL is input only; SDA is only pulled low, open drain.
// (RL18) Suppress input spikes up to 50 ns on the bus lines; the link logic on SCL uses raw SCL and SDA.
// (RL19) Serve register access only when select bit is 0 and pad high.
// (RL20) Controller waits 50 ns after a port switch before starting.
// (RL21) Leave a mismatching address unacknowledged and ignore until START.
// (RL22) On a read not acknowledged, release SDA and wait for START/STOP.
// (RL23) Keep the pointer across the repeated START of a read.
module i2ctr_top
(
  // System clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // I2C pins; scl_clk also clocks the link logic
  input  wire logic                 scl_clk,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe,
  // Host port arbitration
  input  wire logic                 host_port_select_bit,
  input  wire logic                 host_port_select_pad,
  // Fuse-programmed target address
  input  wire logic                 otp_addr_valid,
  input  wire logic [6:0]           otp_addr,
  // Register file access
  output i2ctr_pkg::i2ctr_reg_req_t reg_req,
  input  wire logic [7:0]           reg_rdata,
  // Bus state
  output logic                      bus_busy
);

  // Core (clk) state
  logic                      sel_q, sel_d;
  logic [6:0]                addr_q, addr_d;
  logic                      busy_q, busy_d;
  logic                      sclp_q, sdap_q;
  logic                      t1_q, t2_q, t3_q, seen_q, seen_d;
  logic                      first_q, first_d, inc_q, inc_d;
  logic [7:0]                rd_word_q;
  i2ctr_pkg::i2ctr_reg_req_t req_q, req_d;
  logic                      scl_f, sda_f, pad_f;
  logic                      start_w, stop_w, ev_fire;

  // Link (SCL) state
  logic                      lr1_q, lr2_q, ls1_q, ls2_q;
  logic                      p_q, p_d;
  logic [7:0]                sr_q, sr_d;
  i2ctr_pkg::i2ctr_lk_t      lk_q, lk_d;
  logic                      start_l;

  // Filtered copies of the bus lines and the select pad
  i2ctr_pinfilt u_scl (.clk(clk), .rst(rst), .pin(scl_clk), .level(scl_f));
  i2ctr_pinfilt u_sda (.clk(clk), .rst(rst), .pin(sda_i), .level(sda_f));
  i2ctr_pinfilt u_pad
  (
    .clk   (clk),
    .rst   (rst),
    .pin   (host_port_select_pad),
    .level (pad_f)
  );

  // (RL3) line changes during SCL high
  assign start_w = scl_f && sclp_q && sdap_q && !sda_f;
  assign stop_w  = scl_f && sclp_q && !sdap_q && sda_f;
  // Toggle seen once stages two and three agree
  assign ev_fire = (t2_q == t3_q) && (t3_q != seen_q);

  // Core next state: arbitration, framing, pointer and register requests
  always_comb
  begin
    sel_d       = sel_q;
    addr_d      = addr_q;
    busy_d      = busy_q;
    seen_d      = seen_q;
    first_d     = first_q;
    inc_d       = 1'b0;
    req_d       = req_q;
    req_d.we    = 1'b0;
    req_d.re    = 1'b0;
    // (RL19) port arbitration
    sel_d = !host_port_select_bit && pad_f;
    // (RL1) fuse address load
    if (otp_addr_valid)
      addr_d = otp_addr;
    // (RL4) START opens a frame
    if (start_w)
      busy_d = 1'b1;
    // (RL5) STOP closes it
    else if (stop_w)
      busy_d = 1'b0;
    // Pointer moves one cycle after the access it follows
    if (inc_q)
      req_d.addr = req_q.addr + 8'h01;
    if (ev_fire)
    begin
      seen_d = t3_q;
      if (sel_q)
      begin
        case (lk_q.ev.kind)
          // (RL10) first byte after address+0 is the pointer
          i2ctr_pkg::EV_ADDR_W:
            first_d = 1'b1;
          // (RL23) pointer kept for read
          i2ctr_pkg::EV_ADDR_R:
            first_d = 1'b0;
          i2ctr_pkg::EV_DATA_W:
            if (first_q)
            begin
              req_d.addr = lk_q.ev.data;
              first_d    = 1'b0;
            end
            else
            begin
              // (RL11) store then increment
              req_d.we    = 1'b1;
              req_d.wdata = lk_q.ev.data;
              inc_d       = 1'b1;
            end
          // (RL14) byte sent, next location
          i2ctr_pkg::EV_TX_DONE:
          begin
            req_d.re = 1'b1;
            inc_d    = 1'b1;
          end
          default:
            first_d = 1'b0;
        endcase
      end
    end
  end

  // Core registers; toggle stage one is read by stage two only
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sel_q     <= 1'b0;
      addr_q    <= i2ctr_pkg::TARGET_ADDR_DFLT;
      busy_q    <= 1'b0;
      sclp_q    <= i2ctr_pkg::LINE_IDLE;
      sdap_q    <= i2ctr_pkg::LINE_IDLE;
      t1_q      <= 1'b0;
      t2_q      <= 1'b0;
      t3_q      <= 1'b0;
      seen_q    <= 1'b0;
      first_q   <= 1'b0;
      inc_q     <= 1'b0;
      req_q     <= '0;
      rd_word_q <= 8'h00;
    end
    else
    begin
      sel_q     <= sel_d;
      addr_q    <= addr_d;
      busy_q    <= busy_d;
      sclp_q    <= scl_f;
      sdap_q    <= sda_f;
      t1_q      <= lk_q.ev_tog;
      t2_q      <= t1_q;
      t3_q      <= t2_q;
      seen_q    <= seen_d;
      first_q   <= first_d;
      inc_q     <= inc_d;
      req_q     <= req_d;
      rd_word_q <= reg_rdata;
    end
  end

  // Reset and select level resynchronised onto falling SCL
  always_ff @(negedge scl_clk)
  begin
    lr1_q <= rst;
    lr2_q <= lr1_q;
    ls1_q <= sel_q;
    ls2_q <= ls1_q;
  end

  // Rising SCL: sample data into the shifter, MSB first
  always_comb
  begin
    p_d  = sda_i;
    // (RL2) shift in MSB first
    sr_d = {sr_q[6:0], sda_i};
    if (lr2_q)
    begin
      p_d  = i2ctr_pkg::LINE_IDLE;
      sr_d = 8'h00;
    end
  end

  always_ff @(posedge scl_clk)
  begin
    p_q  <= p_d;
    sr_q <= sr_d;
  end

  // Hand a finished byte to the core; data stays put for a whole byte
  function automatic i2ctr_pkg::i2ctr_lk_t emit(
    input i2ctr_pkg::i2ctr_lk_t      s,
    input i2ctr_pkg::i2ctr_ev_kind_t k,
    input logic [7:0]                b);
    i2ctr_pkg::i2ctr_lk_t r;
    r         = s;
    r.ev.kind = k;
    r.ev.data = b;
    r.ev_tog  = !s.ev_tog;
    return r;
  endfunction

  // Start sending a byte; its first bit goes out at once
  function automatic i2ctr_pkg::i2ctr_lk_t load_tx(
    input i2ctr_pkg::i2ctr_lk_t s,
    input logic [7:0]           w);
    i2ctr_pkg::i2ctr_lk_t r;
    r     = s;
    r.st  = i2ctr_pkg::LK_TX;
    r.tx  = w;
    r.oe  = !w[7];
    r.cnt = 3'h0;
    return r;
  endfunction

  // (RL3) START seen: SDA fell between rising and falling SCL
  assign start_l = p_q && !sda_i;

  // Falling SCL: all SDA changes happen here, never with SCL high.
  // Working on SCL itself keeps High Speed timing free of oversampling.
  // (RL16) mode-independent link timing
  always_comb
  begin
    lk_d = lk_q;
    if (lr2_q)
      lk_d = '0;
    // (RL4) any START restarts the frame
    else if (start_l)
    begin
      lk_d.st  = i2ctr_pkg::LK_ADDR;
      lk_d.cnt = 3'h0;
      lk_d.oe  = 1'b0;
    end
    else
    begin
      case (lk_q.st)
        i2ctr_pkg::LK_ADDR:
          if (lk_q.cnt == i2ctr_pkg::LAST_BIT)
          begin
            // (RL7) match own address and port select
            if (ls2_q && sr_q[7:1] == addr_q)
            begin
              lk_d = emit(lk_q, sr_q[0] ? i2ctr_pkg::EV_ADDR_R
                                        : i2ctr_pkg::EV_ADDR_W, sr_q);
              lk_d.rw = sr_q[0];
              lk_d.oe = 1'b1;
              lk_d.st = i2ctr_pkg::LK_ADDR_ACK;
            end
            else
              // (RL21) no acknowledge, wait for START
              lk_d.st = i2ctr_pkg::LK_IGNORE;
          end
          else
            lk_d.cnt = lk_q.cnt + 3'h1;
        i2ctr_pkg::LK_ADDR_ACK:
          // (RL13) read follows the repeated START
          if (lk_q.rw)
            lk_d = load_tx(lk_q, rd_word_q);
          else
          begin
            lk_d.st  = i2ctr_pkg::LK_RX;
            lk_d.oe  = 1'b0;
            lk_d.cnt = 3'h0;
          end
        i2ctr_pkg::LK_RX:
          // (RL12) only a complete byte is passed on
          if (lk_q.cnt == i2ctr_pkg::LAST_BIT)
          begin
            lk_d    = emit(lk_q, i2ctr_pkg::EV_DATA_W, sr_q);
            // (RL8) acknowledge each written byte
            lk_d.oe = 1'b1;
            lk_d.st = i2ctr_pkg::LK_RX_ACK;
          end
          else
            lk_d.cnt = lk_q.cnt + 3'h1;
        i2ctr_pkg::LK_RX_ACK:
        begin
          lk_d.oe  = 1'b0;
          lk_d.st  = i2ctr_pkg::LK_RX;
          lk_d.cnt = 3'h0;
        end
        i2ctr_pkg::LK_TX:
          if (lk_q.cnt == i2ctr_pkg::LAST_BIT)
          begin
            // (RL6) release SDA for the controller's acknowledge
            lk_d    = emit(lk_q, i2ctr_pkg::EV_TX_DONE, lk_q.tx);
            lk_d.oe = 1'b0;
            lk_d.st = i2ctr_pkg::LK_TX_ACK;
          end
          else
          begin
            // (RL17) drive low only; a one is a released line
            lk_d.cnt = lk_q.cnt + 3'h1;
            lk_d.tx  = {lk_q.tx[6:0], 1'b0};
            lk_d.oe  = !lk_q.tx[6];
          end
        i2ctr_pkg::LK_TX_ACK:
          // (RL9) acknowledged: next byte
          if (!p_q)
            lk_d = load_tx(lk_q, rd_word_q);
          else
          begin
            // (RL22) not acknowledged: stay off the bus
            lk_d.oe = 1'b0;
            lk_d.st = i2ctr_pkg::LK_IGNORE;
          end
        default:
          lk_d.oe = 1'b0;
      endcase
    end
  end

  always_ff @(negedge scl_clk)
  begin
    lk_q <= lk_d;
  end

  // Outputs; SDA data is held low, the enable does the signalling
  assign sda_o    = 1'b0;
  assign sda_oe   = lk_q.oe;
  assign reg_req  = req_q;
  assign bus_busy = busy_q;

  // Link-side sequences
  sequence s_ack_pulse;
    lk_q.oe ##1 !lk_q.oe;
  endsequence

  sequence s_byte_end(i2ctr_pkg::i2ctr_lk_state_t st);
    lk_q.st == st && lk_q.cnt == i2ctr_pkg::LAST_BIT && !start_l;
  endsequence

  // Read address: acknowledge, then the first data bit follows at once
  sequence s_ack_then_tx;
    (lk_q.oe && lk_q.st == i2ctr_pkg::LK_ADDR_ACK)
    ##1 (lk_q.st == i2ctr_pkg::LK_TX);
  endsequence

  // Write direction only; a read may keep SDA low for a zero data bit
  AST_ADDR_ACK: assert property (@(negedge scl_clk) disable iff (lr2_q) // RL7
    (lk_q.st == i2ctr_pkg::LK_ADDR && lk_q.cnt == i2ctr_pkg::LAST_BIT &&
     !start_l && ls2_q && sr_q[7:1] == addr_q && !sr_q[0])
    |=> s_ack_pulse)
    else $error("matching address not acknowledged");

  AST_RD_ADDR: assert property (@(negedge scl_clk) disable iff (lr2_q) // RL13
    (lk_q.st == i2ctr_pkg::LK_ADDR && lk_q.cnt == i2ctr_pkg::LAST_BIT &&
     !start_l && ls2_q && sr_q[7:1] == addr_q && sr_q[0])
    |=> s_ack_then_tx)
    else $error("read address not acknowledged before sending");

  AST_ADDR_NAK: assert property (@(negedge scl_clk) disable iff (lr2_q) // RL21
    (lk_q.st == i2ctr_pkg::LK_ADDR && lk_q.cnt == i2ctr_pkg::LAST_BIT &&
     !start_l && sr_q[7:1] != addr_q)
    |=> (!lk_q.oe && lk_q.st == i2ctr_pkg::LK_IGNORE))
    else $error("foreign address drew a response");

  AST_RX_ACK: assert property (@(negedge scl_clk) disable iff (lr2_q) // RL8
    s_byte_end(i2ctr_pkg::LK_RX) |=> s_ack_pulse)
    else $error("written byte not acknowledged for one bit");

  AST_TX_RELEASE: assert property (@(negedge scl_clk) disable iff (lr2_q) // RL6
    s_byte_end(i2ctr_pkg::LK_TX)
    |=> (!lk_q.oe && lk_q.st == i2ctr_pkg::LK_TX_ACK))
    else $error("SDA held through the controller acknowledge");

  AST_TX_MSB: assert property (@(negedge scl_clk) disable iff (lr2_q) // RL2
    (lk_q.st == i2ctr_pkg::LK_TX) |-> (lk_q.oe == !lk_q.tx[7]))
    else $error("sent bit is not the top bit of the shifter");

  AST_NACK_OFF: assert property (@(negedge scl_clk) disable iff (lr2_q) // RL22
    (lk_q.st == i2ctr_pkg::LK_TX_ACK && p_q && !start_l)
    |=> (!lk_q.oe [*2]))
    else $error("SDA driven after a missing acknowledge");

  AST_FULL_BYTE: assert property (@(negedge scl_clk) disable iff (lr2_q) // RL12
    (lk_d.ev_tog != lk_q.ev_tog) |-> (lk_q.cnt == i2ctr_pkg::LAST_BIT))
    else $error("byte passed on before its eighth bit");

  AST_OPEN_DRAIN: assert property (@(negedge scl_clk) disable iff (lr2_q) // RL17
    sda_oe |-> (sda_o == 1'b0 && lk_q.st inside {i2ctr_pkg::LK_ADDR_ACK,
                i2ctr_pkg::LK_RX_ACK, i2ctr_pkg::LK_TX}))
    else $error("SDA pulled low outside acknowledge or send");

  // Core-side checks
  AST_WR_INC: assert property (@(posedge clk) disable iff (rst) // RL11
    reg_req.we |=> (reg_req.addr == $past(reg_req.addr) + 8'h01))
    else $error("pointer not advanced after a write");

  AST_RD_INC: assert property (@(posedge clk) disable iff (rst) // RL14
    reg_req.re |=> (reg_req.addr == $past(reg_req.addr) + 8'h01))
    else $error("pointer not advanced after a sent byte");

  AST_PTR_KEEP: assert property (@(posedge clk) disable iff (rst) // RL23
    (ev_fire && sel_q && !inc_q && lk_q.ev.kind == i2ctr_pkg::EV_ADDR_R)
    |=> $stable(reg_req.addr))
    else $error("pointer lost at repeated START");

  AST_SEL_GATE: assert property (@(posedge clk) disable iff (rst) // RL19
    (reg_req.we || reg_req.re) |-> $past(sel_q))
    else $error("register access while port not selected");

  AST_START_BUSY: assert property (@(posedge clk) disable iff (rst) // RL4
    start_w |=> busy_q ##0 (busy_q || $past(stop_w)))
    else $error("START did not open a frame");

  AST_STOP_IDLE: assert property (@(posedge clk) disable iff (rst) // RL5
    (stop_w && !start_w) |=> !busy_q)
    else $error("STOP did not close the frame");

endmodule

// ---- verification/i2ctr_ctl.sv ----
// Behavioural I2C bus controller facing the register target
`timescale 1ns/1ps
module i2ctr_ctl
(
  // Bus lines; SDA is open drain with a pull-up
  output logic       scl,
  output logic       sda_pull,
  input  wire logic  sda,
  // Last byte read back from the target
  output logic [7:0] got,
  output logic       got_tog
);
  // Low phase of SCL in ns; the high phase is fixed at 32 ns
  int lo_ns;

  // Idle bus: SCL high and SDA released
  initial
  begin
    lo_ns    = 32;
    scl      = 1'b1;
    sda_pull = 1'b0;
    got      = 8'h00;
    got_tog  = 1'b0;
  end

  task automatic bit_cyc(input logic b, output logic s);
    #(lo_ns / 2);
    sda_pull = !b;
    #(lo_ns - lo_ns / 2);
    scl = 1'b1;
    s = sda;
    #32;
    scl = 1'b0;
  endtask

  // Long phases so the clk-side spike filter sees START
  task automatic start();
    scl = 1'b0;
    #(lo_ns / 2);
    sda_pull = 1'b0;
    #(lo_ns / 2);
    scl = 1'b1;
    #400;
    sda_pull = 1'b1;
    #400;
    scl = 1'b0;
    #400;
  endtask

  task automatic stop();
    #(lo_ns / 2);
    sda_pull = 1'b1;
    #400;
    scl = 1'b1;
    #400;
    sda_pull = 1'b0;
    #400;
  endtask

  task automatic send_bits(input logic [7:0] b, input int n);
    logic s;
    for (int i = 7; i > 7 - n; i--)
      bit_cyc(b[i], s);
  endtask

  // SDA released for the ninth clock
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    send_bits(b, 8);
    bit_cyc(1'b1, s);
    ack = (s === 1'b0);
  endtask

  // acknowledge only the bytes still wanted
  task automatic recv(input logic more);
    logic [7:0] b;
    logic       s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_cyc(1'b1, s);
      b[i] = s;
    end
    bit_cyc(!more, s);
    got = b;
    got_tog = !got_tog;
  endtask

  // Free clocks with SDA released, used around reset only
  task automatic pulses(input int n);
    logic s;
    repeat (n) bit_cyc(1'b1, s);
  endtask
endmodule

// ---- verification/i2ctr_top_tb.sv ----
// Self-checking bench for the I2C register target
`timescale 1ns/1ps
module i2ctr_top_tb;
  // Design pins and bench state
  logic                      clk;
  logic                      rst;
  logic                      scl;
  logic                      pull;
  logic                      sda_o;
  logic                      sda_oe;
  logic                      host_port_select_bit;
  logic                      host_port_select_pad;
  logic                      otp_addr_valid;
  logic [6:0]                otp_addr;
  i2ctr_pkg::i2ctr_reg_req_t reg_req;
  logic                      bus_busy;
  logic [7:0]                got;
  logic                      got_tog;
  logic [7:0]                mem [256];
  logic [15:0]               wq [$];
  logic [7:0]                rq [$];
  logic [7:0]                aq [$];
  logic [31:0]               seed;
  logic [7:0]                p;
  int                        err_count;
  int                        checked;
  int                        cycles;
  wire logic                 sda;

  // Wired-AND line: pulled up unless a party pulls low
  assign sda = !(pull || (sda_oe && !sda_o));

  initial clk = 1'b0;
  always #20 clk = !clk;

  i2ctr_top i2ctr_top_i (
    .clk(clk), .rst(rst), .scl_clk(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe),
    .host_port_select_bit(host_port_select_bit),
    .host_port_select_pad(host_port_select_pad),
    .otp_addr_valid(otp_addr_valid), .otp_addr(otp_addr),
    .reg_req(reg_req), .reg_rdata(mem[reg_req.addr]),
    .bus_busy(bus_busy)
  );

  i2ctr_ctl i2ctr_ctl_i (
    .scl(scl), .sda_pull(pull), .sda(sda), .got(got), .got_tog(got_tog)
  );

  // Xorshift source; state kept across calls
  function logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic check(input string w, input logic [7:0] s,
                       input logic [7:0] e);
    checked++;
    if (s !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", w, e, s);
    end
  endtask

  task automatic wrap_up();
    if (err_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Address, pointer and n data bytes; STOP is left to the caller
  task automatic wr_frame(input logic [6:0] a, input logic [7:0] pt,
                          input int n, input logic want);
    logic       k;
    logic [7:0] d;
    i2ctr_ctl_i.start();
    check("busy_on", {7'h00, bus_busy}, 8'h01);
    i2ctr_ctl_i.send({a, 1'b0}, k);
    check("ack_a", {7'h00, k}, {7'h00, want});
    i2ctr_ctl_i.send(pt, k);
    check("ack_p", {7'h00, k}, {7'h00, want});
    for (int i = 0; i < n; i++)
    begin
      d = rnd();
      if (want)
        wq.push_back({pt + 8'(i), d});
      i2ctr_ctl_i.send(d, k);
      check("ack_d", {7'h00, k}, {7'h00, want});
    end
  endtask

  task automatic fin();
    i2ctr_ctl_i.stop();
    check("busy_off", {7'h00, bus_busy}, 8'h00);
  endtask

  // Dummy write, repeated START, then n bytes with NACK on the last
  task automatic rd_frame(input logic [7:0] pt, input int n);
    logic k;
    wr_frame(7'h1f, pt, 0, 1'b1);
    i2ctr_ctl_i.lo_ns = 400;
    i2ctr_ctl_i.start();
    i2ctr_ctl_i.send({7'h1f, 1'b1}, k);
    check("ack_r", {7'h00, k}, 8'h01);
    for (int i = 0; i < n; i++)
    begin
      rq.push_back(mem[pt + 8'(i)]);
      aq.push_back(pt + 8'(i));
      i2ctr_ctl_i.recv(i < n - 1);
    end
    i2ctr_ctl_i.bit_cyc(1'b1, k);
    check("quiet", {7'h00, k}, 8'h01);
    fin();
    i2ctr_ctl_i.lo_ns = 32;
  endtask

  // Register file: strobes matched in order, data stored
  always @(posedge clk)
  begin
    if (reg_req.we === 1'b1)
    begin
      mem[reg_req.addr] <= reg_req.wdata;
      if (wq.size() == 0)
        check("we_extra", 8'h01, 8'h00);
      else
      begin
        check("wr_a", reg_req.addr, wq[0][15:8]);
        check("wr_d", reg_req.wdata, wq[0][7:0]);
        void'(wq.pop_front());
      end
    end
    // Read strobe marks each sent byte at its own location
    if (reg_req.re === 1'b1)
    begin
      if (aq.size() == 0)
        check("re_extra", 8'h01, 8'h00);
      else
      begin
        check("re_a", reg_req.addr, aq[0]);
        void'(aq.pop_front());
      end
    end
  end

  // Bytes read by the controller against the oldest note
  always @(got_tog)
  begin
    if ($time > 0)
    begin
      if (rq.size() == 0)
        check("rd_extra", 8'h01, 8'h00);
      else
      begin
        check("rd", got, rq[0]);
        void'(rq.pop_front());
      end
    end
  end

  // Hang guard, far above the roughly 1700 cycles needed
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      wrap_up();
    end
  end

  initial
  begin
    seed = 32'h2a7f741f;
    err_count = 0;
    checked = 0;
    cycles = 0;
    rst = 1'b1;
    host_port_select_bit = 1'b0;
    host_port_select_pad = 1'b1;
    otp_addr_valid = 1'b0;
    otp_addr = 7'h00;
    for (int i = 0; i < 256; i++)
      mem[i] = rnd();
    // Link flops need falling SCL edges to see reset
    i2ctr_ctl_i.pulses(4);
    repeat (6) @(negedge clk);
    rst = 1'b0;
    i2ctr_ctl_i.pulses(2);
    repeat (4) @(negedge clk);
    check("sda_o", {7'h00, sda_o}, 8'h00);
    check("rst_oe", {7'h00, sda_oe}, 8'h00);
    check("rst_busy", {7'h00, bus_busy}, 8'h00);
    // Burst write then read back across the written bytes
    p = rnd() & 8'h7f;
    wr_frame(7'h1f, p, 3, 1'b1);
    fin();
    rd_frame(p, 4);
    // Byte cut short by STOP must not be written
    wr_frame(7'h1f, p + 8'h10, 1, 1'b1);
    i2ctr_ctl_i.send_bits(rnd(), 5);
    fin();
    // Foreign address stays unanswered
    wr_frame(7'h1e, p, 2, 1'b0);
    fin();
    // Every select combination; settle well past 50 ns first
    for (int i = 0; i < 4; i++)
    begin
      @(negedge clk);
      host_port_select_bit = i[1];
      host_port_select_pad = i[0];
      repeat (8) @(negedge clk);
      wr_frame(7'h1f, rnd(), 1, !i[1] && i[0]);
      fin();
    end
    // Fuse address replaces the default one
    @(negedge clk);
    host_port_select_bit = 1'b0;
    host_port_select_pad = 1'b1;
    otp_addr_valid = 1'b1;
    otp_addr = 7'h35;
    repeat (8) @(negedge clk);
    wr_frame(7'h35, rnd(), 2, 1'b1);
    fin();
    wr_frame(7'h1f, rnd(), 1, 1'b0);
    fin();
    repeat (20) @(negedge clk);
    check("wq_left", 8'(wq.size()), 8'h00);
    check("rq_left", 8'(rq.size()), 8'h00);
    check("aq_left", 8'(aq.size()), 8'h00);
    wrap_up();
  end
endmodule
